/* verilog/duw_pkg.sv */
// Notes on behaviour
// - Write address user bits 31:19 carry queue number; bits 18:0 reserved zero.
// - Every write address carries a four-bit transaction identifier.
// - Every write address carries an eight-bit burst length.
// - Write address carries burst type, beat size, protection, lock, memory type.
// - Address valid held with address until user logic gives address ready.
// - With protection on, one odd-parity bit per write data byte.
// - Every stream beat carries a CRC-32 (Ethernet polynomial) of that beat.
// - Packet error flag set from first failing beat to packet end.
// - Packet error flag starts clear on each new packet.
// - Descriptor low 32 bits ride on the metadata sideband.
// - Last beat carries six-bit invalid byte count; zero for full beat.
// - Empty beat flag marks a beat transferring no data bytes.
// - Stream last only on the final beat of a packet.
package duw_pkg;
  // Register offsets
  localparam logic [7:0] DUW_CTRL_ADDR     = 8'h00;
  localparam logic [7:0] DUW_MM_ADDR_LO    = 8'h04;
  localparam logic [7:0] DUW_MM_ADDR_HI    = 8'h08;
  localparam logic [7:0] DUW_MM_CFG_ADDR   = 8'h0c;
  localparam logic [7:0] DUW_SEED_ADDR     = 8'h10;
  localparam logic [7:0] DUW_ST_CFG_ADDR   = 8'h14;
  localparam logic [7:0] DUW_ST_META_ADDR  = 8'h18;
  localparam logic [7:0] DUW_STATUS_ADDR   = 8'h1c;
  localparam logic [7:0] DUW_INT_STAT_ADDR = 8'h20;
  localparam logic [7:0] DUW_INT_MASK_ADDR = 8'h24;
  localparam logic [7:0] DUW_ST_ERR_ADDR   = 8'h28;
  // Control bits
  localparam int DUW_CTRL_MM_GO  = 0;
  localparam int DUW_CTRL_ST_GO  = 1;
  // Interrupt bits
  localparam int DUW_INT_W       = 3;
  localparam int DUW_INT_MM_DONE = 0;
  localparam int DUW_INT_ST_DONE = 1;
  localparam int DUW_INT_BERR    = 2;
  // Address channel constants
  localparam int         DUW_ADDR_W    = 64;
  localparam int         DUW_QNUM_LSB  = 19;
  localparam logic [1:0] DUW_BURST_INC = 2'h1;
  localparam logic [2:0] DUW_PROT_DEF  = 3'h0;
  localparam logic [3:0] DUW_CACHE_DEF = 4'h3;
  localparam logic [1:0] DUW_RESP_OKAY = 2'h0;
  localparam logic [7:0] DUW_BEAT_BYTES_MAX = 8'h40;
  // Write address carrier
  typedef struct packed {
    logic [DUW_ADDR_W-1:0] addr;
    logic [3:0]            id;
    logic [31:0]           user;
    logic [7:0]            len;
    logic [2:0]            size;
    logic [1:0]            burst;
    logic [2:0]            prot;
    logic                  lock;
    logic [3:0]            cache;
  } duw_aw_t;
  // Stream sideband carrier
  typedef struct packed {
    logic [31:0] outbound_beat_crc;
    logic [10:0] outbound_queue_id;
    logic [2:0]  outbound_port_id;
    logic        outbound_packet_error;
    logic [31:0] outbound_descriptor_metadata;
    logic [5:0]  outbound_empty_byte_count;
    logic        outbound_empty_beat_flag;
    logic        last;
  } duw_side_t;
  // Write path states
  typedef enum logic [1:0] {
    DUW_M_IDLE = 2'b00,
    DUW_M_ADDR = 2'b01,
    DUW_M_DATA = 2'b10,
    DUW_M_RESP = 2'b11
  } duw_mstate_t;
  // Stream states
  typedef enum logic {
    DUW_S_IDLE = 1'b0,
    DUW_S_RUN  = 1'b1
  } duw_sstate_t;
endpackage : duw_pkg

/* verilog/duw_top.sv */
// Chosen here: the plain strobed port and the register addresses.
`timescale 1ns/100ps
module duw_top import duw_pkg::*; #(
  parameter int MM_DW   = 256,
  parameter int ST_DW   = 512,
  parameter bit DP_EN   = 1'b1
) (
  // Clock and reset
  input  wire logic                  ref_clk,
  input  wire logic                  rst_b,
  // Register port
  input  wire logic [7:0]            reg_addr,
  input  wire logic [31:0]           reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output logic      [31:0]           reg_rdata,
  output logic                       irq,
  // Memory-mapped write address
  output duw_aw_t                    m_axi_aw,
  output logic                       m_axi_awvalid,
  input  wire logic                  m_axi_awready,
  // Memory-mapped write data
  output logic      [MM_DW-1:0]      m_axi_wdata,
  output logic      [MM_DW/8-1:0]    m_axi_wstrb,
  output logic      [MM_DW/8-1:0]    m_axi_wuser,
  output logic                       m_axi_wlast,
  output logic                       m_axi_wvalid,
  input  wire logic                  m_axi_wready,
  // Memory-mapped write response
  input  wire logic                  m_axi_bvalid,
  input  wire logic [1:0]            m_axi_bresp,
  input  wire logic [3:0]            m_axi_bid,
  output logic                       m_axi_bready,
  // Host-to-card stream
  output logic      [ST_DW-1:0]      host_to_card_tdata,
  output duw_side_t                  host_to_card_side,
  output logic                       host_to_card_tvalid,
  input  wire logic                  host_to_card_tready
);

  // Refuse widths the data generators and empty count cannot serve
  if (MM_DW % 32 != 0 || MM_DW < 32 || MM_DW > 1024) begin : g_mm_chk
    $error("MM_DW must be a multiple of 32 from 32 to 1024");
  end
  if (ST_DW % 32 != 0 || ST_DW < 32 || ST_DW > 512) begin : g_st_chk
    $error("ST_DW must be a multiple of 32 from 32 to 512");
  end

  localparam logic [2:0] MM_SIZE = 3'($clog2(MM_DW / 8));

  // Reflected CRC-32 over every byte of the beat, low byte first
  function automatic logic [31:0] beat_crc(input logic [ST_DW-1:0] d);
    logic [31:0] c;
    c = 32'hffffffff;
    for (int i = 0; i < ST_DW; i++) begin
      if (c[0] ^ d[i]) begin
        c = (c >> 1) ^ 32'hedb88320;
      end else begin
        c = c >> 1;
      end
    end
    return ~c;
  endfunction : beat_crc

  // Software state
  logic [DUW_ADDR_W-1:0] mm_addr_reg, mm_addr_next;
  logic [31:0]           mm_cfg_reg, mm_cfg_next;
  logic [31:0]           seed_reg, seed_next;
  logic [31:0]           st_cfg_reg, st_cfg_next;
  logic [31:0]           st_meta_reg, st_meta_next;
  logic [8:0]            st_err_reg, st_err_next;
  logic [DUW_INT_W-1:0]  int_stat_reg, int_stat_next;
  logic [DUW_INT_W-1:0]  int_mask_reg, int_mask_next;
  logic [31:0]           rdata_reg, rdata_next;
  logic [1:0]            last_resp_reg, last_resp_next;
  logic [3:0]            last_bid_reg, last_bid_next;
  logic                  mm_go, st_go;
  logic [DUW_INT_W-1:0]  ev;
  logic                  st_done_ev;

  // Write path state
  duw_mstate_t           mst_reg, mst_next;
  duw_aw_t               aw_reg, aw_next;
  logic [7:0]            mbeat_reg, mbeat_next;
  logic [MM_DW-1:0]      wdata_reg, wdata_next;
  logic [MM_DW/8-1:0]    wpar_reg, wpar_next;

  // Stream state
  duw_sstate_t           sst_reg, sst_next;
  logic [7:0]            sbeat_reg, sbeat_next;
  logic [ST_DW-1:0]      tdata_reg, tdata_next;
  duw_side_t             side_reg, side_next;
  logic [7:0]            pk_beats_reg, pk_beats_next;
  logic [5:0]            pk_mty_reg, pk_mty_next;
  logic                  pk_zero_reg, pk_zero_next;
  logic [8:0]            pk_err_reg, pk_err_next;
  logic [31:0]           pk_seed_reg, pk_seed_next;

  assign mm_go = reg_wr && reg_addr == DUW_CTRL_ADDR &&
                 reg_wdata[DUW_CTRL_MM_GO];
  assign st_go = reg_wr && reg_addr == DUW_CTRL_ADDR &&
                 reg_wdata[DUW_CTRL_ST_GO];

  // Register file: writes, read mux, sticky interrupt status
  always_comb begin
    mm_addr_next   = mm_addr_reg;
    mm_cfg_next    = mm_cfg_reg;
    seed_next      = seed_reg;
    st_cfg_next    = st_cfg_reg;
    st_meta_next   = st_meta_reg;
    st_err_next    = st_err_reg;
    int_mask_next  = int_mask_reg;
    int_stat_next  = int_stat_reg;
    rdata_next     = 32'h0;
    last_resp_next = last_resp_reg;
    last_bid_next  = last_bid_reg;
    if (reg_wr) begin
      case (reg_addr)
        DUW_MM_ADDR_LO:    mm_addr_next[31:0]  = reg_wdata;
        DUW_MM_ADDR_HI:    mm_addr_next[63:32] = reg_wdata;
        DUW_MM_CFG_ADDR:   mm_cfg_next   = reg_wdata;
        DUW_SEED_ADDR:     seed_next     = reg_wdata;
        DUW_ST_CFG_ADDR:   st_cfg_next   = reg_wdata;
        DUW_ST_META_ADDR:  st_meta_next  = reg_wdata;
        DUW_ST_ERR_ADDR:   st_err_next   = reg_wdata[8:0];
        DUW_INT_MASK_ADDR: int_mask_next = reg_wdata[DUW_INT_W-1:0];
        default:           ;
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        DUW_MM_ADDR_LO:    rdata_next = mm_addr_reg[31:0];
        DUW_MM_ADDR_HI:    rdata_next = mm_addr_reg[63:32];
        DUW_MM_CFG_ADDR:   rdata_next = mm_cfg_reg;
        DUW_SEED_ADDR:     rdata_next = seed_reg;
        DUW_ST_CFG_ADDR:   rdata_next = st_cfg_reg;
        DUW_ST_META_ADDR:  rdata_next = st_meta_reg;
        DUW_ST_ERR_ADDR:   rdata_next = {23'h0, st_err_reg};
        DUW_STATUS_ADDR:   rdata_next = {24'h0, last_bid_reg, last_resp_reg,
                                         sst_reg == DUW_S_RUN,
                                         mst_reg != DUW_M_IDLE};
        DUW_INT_STAT_ADDR: rdata_next = {29'h0, int_stat_reg};
        DUW_INT_MASK_ADDR: rdata_next = {29'h0, int_mask_reg};
        default:           rdata_next = 32'h0;
      endcase
      // Read clears status; a same-cycle event still lands below
      if (reg_addr == DUW_INT_STAT_ADDR) begin
        int_stat_next = '0;
      end
    end
    if (m_axi_bvalid && m_axi_bready) begin
      last_resp_next = m_axi_bresp;
      last_bid_next  = m_axi_bid;
    end
    int_stat_next = int_stat_next | ev;
    // Stream done comes from its own process so each flag has one driver
    int_stat_next[DUW_INT_ST_DONE] = int_stat_next[DUW_INT_ST_DONE] ||
                                     st_done_ev;
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      mm_addr_reg   <= '0;
      mm_cfg_reg    <= 32'h0;
      seed_reg      <= 32'h0;
      st_cfg_reg    <= 32'h0;
      st_meta_reg   <= 32'h0;
      st_err_reg    <= 9'h0;
      int_stat_reg  <= '0;
      int_mask_reg  <= '0;
      rdata_reg     <= 32'h0;
      last_resp_reg <= 2'h0;
      last_bid_reg  <= 4'h0;
    end else begin
      mm_addr_reg   <= mm_addr_next;
      mm_cfg_reg    <= mm_cfg_next;
      seed_reg      <= seed_next;
      st_cfg_reg    <= st_cfg_next;
      st_meta_reg   <= st_meta_next;
      st_err_reg    <= st_err_next;
      int_stat_reg  <= int_stat_next;
      int_mask_reg  <= int_mask_next;
      rdata_reg     <= rdata_next;
      last_resp_reg <= last_resp_next;
      last_bid_reg  <= last_bid_next;
    end
  end

  assign reg_rdata = rdata_reg;
  assign irq       = |(int_stat_reg & int_mask_reg);

  // Memory-mapped write path: address, then beats, then response
  always_comb begin
    logic [31:0] word;
    word       = 32'h0;
    mst_next   = mst_reg;
    aw_next    = aw_reg;
    mbeat_next = mbeat_reg;
    wdata_next = wdata_reg;
    wpar_next  = wpar_reg;
    ev         = '0;
    case (mst_reg)
      DUW_M_IDLE: begin
        if (mm_go) begin
          aw_next.addr  = mm_addr_reg;
          aw_next.len   = mm_cfg_reg[7:0];
          aw_next.id    = mm_cfg_reg[11:8];
          aw_next.user  = {mm_cfg_reg[24:12],
                           DUW_QNUM_LSB'(0)};
          aw_next.size  = MM_SIZE;
          aw_next.burst = DUW_BURST_INC;
          aw_next.prot  = DUW_PROT_DEF;
          aw_next.lock  = 1'b0;
          aw_next.cache = DUW_CACHE_DEF;
          mbeat_next    = 8'h0;
          mst_next      = DUW_M_ADDR;
        end
      end
      DUW_M_ADDR: begin
        // Address stays put until the slave takes it
        if (m_axi_awready) begin
          mst_next = DUW_M_DATA;
        end
      end
      DUW_M_DATA: begin
        if (m_axi_wready) begin
          if (mbeat_reg == aw_reg.len) begin
            mst_next = DUW_M_RESP;
          end else begin
            mbeat_next = mbeat_reg + 8'h1;
          end
        end
      end
      DUW_M_RESP: begin
        if (m_axi_bvalid && m_axi_bready) begin
          mst_next = DUW_M_IDLE;
          ev[DUW_INT_MM_DONE] = 1'b1;
          ev[DUW_INT_BERR]    = m_axi_bresp != DUW_RESP_OKAY;
        end
      end
      default: mst_next = DUW_M_IDLE;
    endcase
    // Beat data is a seeded count so a sink can check it
    word       = seed_reg + {24'h0, mbeat_next};
    wdata_next = {(MM_DW/32){word}};
    for (int b = 0; b < MM_DW / 8; b++) begin
      wpar_next[b] = DP_EN ? ~^wdata_next[b*8 +: 8] : 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      mst_reg   <= DUW_M_IDLE;
      aw_reg    <= '0;
      mbeat_reg <= 8'h0;
      wdata_reg <= '0;
      wpar_reg  <= '0;
    end else begin
      mst_reg   <= mst_next;
      aw_reg    <= aw_next;
      mbeat_reg <= mbeat_next;
      wdata_reg <= wdata_next;
      wpar_reg  <= wpar_next;
    end
  end

  assign m_axi_aw      = aw_reg;
  assign m_axi_awvalid = mst_reg == DUW_M_ADDR;
  assign m_axi_wdata   = wdata_reg;
  assign m_axi_wuser   = wpar_reg;
  assign m_axi_wstrb   = '1;
  assign m_axi_wvalid  = mst_reg == DUW_M_DATA;
  assign m_axi_wlast   = m_axi_wvalid && mbeat_reg == aw_reg.len;
  // Only a response naming the issued id is taken
  assign m_axi_bready  = mst_reg == DUW_M_RESP && m_axi_bvalid &&
                         m_axi_bid == aw_reg.id;

  // Stream packet generator; next beat is built only after a handshake
  always_comb begin
    logic        load;
    logic [7:0]  idx;
    logic [31:0] word;
    load          = 1'b0;
    idx           = 8'h0;
    word          = 32'h0;
    sst_next      = sst_reg;
    sbeat_next    = sbeat_reg;
    tdata_next    = tdata_reg;
    side_next     = side_reg;
    pk_beats_next = pk_beats_reg;
    pk_mty_next   = pk_mty_reg;
    pk_zero_next  = pk_zero_reg;
    pk_err_next   = pk_err_reg;
    pk_seed_next  = pk_seed_reg;
    st_done_ev    = 1'b0;
    case (sst_reg)
      DUW_S_IDLE: begin
        if (st_go) begin
          pk_beats_next = st_cfg_reg[15] ? 8'h0 : st_cfg_reg[7:0];
          pk_mty_next   = st_cfg_reg[13:8];
          pk_zero_next  = st_cfg_reg[15];
          pk_err_next   = st_err_reg;
          pk_seed_next  = seed_reg;
          side_next.outbound_queue_id = st_cfg_reg[30:20];
          side_next.outbound_port_id  = st_cfg_reg[18:16];
          side_next.outbound_descriptor_metadata = st_meta_reg;
          side_next.outbound_packet_error = 1'b0;
          load     = 1'b1;
          idx      = 8'h0;
          sst_next = DUW_S_RUN;
        end
      end
      DUW_S_RUN: begin
        // Beat and sidebands hold until the sink takes them
        if (host_to_card_tready) begin
          if (side_reg.last) begin
            sst_next = DUW_S_IDLE;
            st_done_ev = 1'b1;
          end else begin
            load = 1'b1;
            idx  = sbeat_reg + 8'h1;
          end
        end
      end
      default: sst_next = DUW_S_IDLE;
    endcase
    if (load) begin
      sbeat_next = idx;
      word       = pk_seed_next + {24'h0, idx};
      tdata_next = {(ST_DW/32){word}};
      side_next.outbound_beat_crc = beat_crc(tdata_next);
      side_next.last = idx == pk_beats_next;
      side_next.outbound_empty_byte_count =
        side_next.last ? pk_mty_next : 6'h0;
      side_next.outbound_empty_beat_flag = pk_zero_next;
      // Once seen, the error sticks to the end of the packet
      side_next.outbound_packet_error =
        side_next.outbound_packet_error ||
        (pk_err_next[8] && idx == pk_err_next[7:0]);
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      sst_reg      <= DUW_S_IDLE;
      sbeat_reg    <= 8'h0;
      tdata_reg    <= '0;
      side_reg     <= '0;
      pk_beats_reg <= 8'h0;
      pk_mty_reg   <= 6'h0;
      pk_zero_reg  <= 1'b0;
      pk_err_reg   <= 9'h0;
      pk_seed_reg  <= 32'h0;
    end else begin
      sst_reg      <= sst_next;
      sbeat_reg    <= sbeat_next;
      tdata_reg    <= tdata_next;
      side_reg     <= side_next;
      pk_beats_reg <= pk_beats_next;
      pk_mty_reg   <= pk_mty_next;
      pk_zero_reg  <= pk_zero_next;
      pk_err_reg   <= pk_err_next;
      pk_seed_reg  <= pk_seed_next;
    end
  end

  assign host_to_card_tdata  = tdata_reg;
  assign host_to_card_side   = side_reg;
  assign host_to_card_tvalid = sst_reg == DUW_S_RUN;

endmodule : duw_top

/* dv/duw_asserts.sv */
`timescale 1ns/100ps
module duw_checker import duw_pkg::*; #(
  parameter int MM_DW = 256,
  parameter int ST_DW = 512,
  parameter bit DP_EN = 1'b1
) (
  // Clock and reset
  input logic               ref_clk,
  input logic               rst_b,
  // Write channels
  input duw_aw_t            m_axi_aw,
  input logic               m_axi_awvalid,
  input logic               m_axi_awready,
  input logic [MM_DW-1:0]   m_axi_wdata,
  input logic [MM_DW/8-1:0] m_axi_wstrb,
  input logic [MM_DW/8-1:0] m_axi_wuser,
  input logic               m_axi_wlast,
  input logic               m_axi_wvalid,
  input logic               m_axi_wready,
  input logic               m_axi_bvalid,
  input logic [3:0]         m_axi_bid,
  input logic               m_axi_bready,
  // Stream
  input logic [ST_DW-1:0]   host_to_card_tdata,
  input duw_side_t          host_to_card_side,
  input logic               host_to_card_tvalid,
  input logic               host_to_card_tready
);
  logic [3:0] id_q;
  logic [7:0] len_q;
  logic [7:0] beat_q;

  function automatic logic [MM_DW/8-1:0] odd_par(input logic [MM_DW-1:0] d);
    for (int i = 0; i < MM_DW / 8; i++) odd_par[i] = ~^d[8*i+:8];
  endfunction : odd_par

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  // Issued id, announced length and beats sent so far
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      id_q   <= 4'h0;
      len_q  <= 8'h00;
      beat_q <= 8'h00;
    end else if (m_axi_awvalid && m_axi_awready) begin
      id_q   <= m_axi_aw.id;
      len_q  <= m_axi_aw.len;
      beat_q <= 8'h00;
    end else if (m_axi_wvalid && m_axi_wready) begin
      beat_q <= beat_q + 8'h01;
    end
  end

  aw_user_a: assert property (m_axi_awvalid |-> m_axi_aw.user[18:0] == '0)
    else $error("aw user low bits set");
  aw_hold_a: assert property (m_axi_awvalid && !m_axi_awready |=>
    m_axi_awvalid && $stable(m_axi_aw)) else $error("aw dropped");
  aw_attr_a: assert property (m_axi_awvalid |->
    m_axi_aw.burst == DUW_BURST_INC && m_axi_aw.size == $clog2(MM_DW / 8))
    else $error("aw attributes");
  w_parity_a: assert property (m_axi_wvalid |->
    m_axi_wuser == (DP_EN ? odd_par(m_axi_wdata) : '0)) else $error("parity");
  w_strb_a: assert property (m_axi_wvalid |-> &m_axi_wstrb)
    else $error("strobe");
  w_hold_a: assert property (m_axi_wvalid && !m_axi_wready |=> m_axi_wvalid
    && $stable(m_axi_wdata) && $stable(m_axi_wlast)) else $error("w dropped");
  w_last_a: assert property (m_axi_wvalid |-> m_axi_wlast == (beat_q == len_q))
    else $error("wlast position");
  b_match_a: assert property (m_axi_bready |-> m_axi_bvalid && m_axi_bid == id_q)
    else $error("bready for foreign id");
  st_hold_a: assert property (host_to_card_tvalid && !host_to_card_tready |=>
    host_to_card_tvalid && $stable(host_to_card_side)
    && $stable(host_to_card_tdata)) else $error("beat not held");
  st_err_a: assert property (host_to_card_tvalid && host_to_card_tready &&
    !host_to_card_side.last && host_to_card_side.outbound_packet_error |=>
    host_to_card_side.outbound_packet_error) else $error("error flag lost");
  st_ids_a: assert property (host_to_card_tvalid && host_to_card_tready &&
    !host_to_card_side.last |=> $stable(host_to_card_side.outbound_queue_id)
    && $stable(host_to_card_side.outbound_port_id)) else $error("ids moved");
  st_empty_a: assert property (host_to_card_tvalid &&
    host_to_card_side.outbound_empty_beat_flag |-> host_to_card_side.last)
    else $error("empty beat not last");
endmodule : duw_checker

bind duw_top duw_checker #(.MM_DW(MM_DW), .ST_DW(ST_DW), .DP_EN(DP_EN))
  duw_checker_i (.*);

/* dv/duw_partner.sv */
`timescale 1ns/100ps
module duw_partner import duw_pkg::*; (
  // Clock and reset
  input  logic       ref_clk,
  input  logic       rst_b,
  // Write channels, slave side
  input  duw_aw_t    m_axi_aw,
  input  logic       m_axi_awvalid,
  output logic       m_axi_awready,
  input  logic       m_axi_wvalid,
  input  logic       m_axi_wlast,
  output logic       m_axi_wready,
  output logic       m_axi_bvalid,
  output logic [1:0] m_axi_bresp,
  output logic [3:0] m_axi_bid,
  input  logic       m_axi_bready,
  // Stream sink and response code chosen by the bench
  input  logic       host_to_card_tvalid,
  output logic       host_to_card_tready,
  input  logic [1:0] resp_code
);
  logic [3:0] id_q;
  logic       pend;

  // Random stalls; response held until taken, then the bus shows junk
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      {m_axi_awready, m_axi_wready, host_to_card_tready} <= 3'h0;
      {m_axi_bvalid, m_axi_bresp, m_axi_bid, id_q, pend} <= 12'h000;
    end else begin
      m_axi_awready       <= ($urandom % 3) != 0;
      m_axi_wready        <= ($urandom % 3) != 0;
      host_to_card_tready <= ($urandom % 4) != 0;
      if (m_axi_awvalid && m_axi_awready) id_q <= m_axi_aw.id;
      if (m_axi_wvalid && m_axi_wready && m_axi_wlast) pend <= 1'b1;
      if (m_axi_bvalid && m_axi_bready) begin
        m_axi_bvalid <= 1'b0;
        m_axi_bid    <= ~m_axi_bid;
        m_axi_bresp  <= ~m_axi_bresp;
      end else if (pend && !m_axi_bvalid && $urandom % 2 == 1) begin
        m_axi_bvalid <= 1'b1;
        m_axi_bid    <= id_q;
        m_axi_bresp  <= resp_code;
        pend         <= 1'b0;
      end
    end
  end
endmodule : duw_partner

/* dv/duw_tb_top.sv */
`timescale 1ns/100ps
module duw_tb_top import duw_pkg::*; ;
  localparam int MW = 256;
  localparam int SW = 512;
  logic            ref_clk, rst_b, reg_wr, reg_rd, irq;
  logic [7:0]      reg_addr;
  logic [31:0]     reg_wdata, reg_rdata;
  duw_aw_t         m_axi_aw;
  logic            m_axi_awvalid, m_axi_awready, m_axi_wlast, m_axi_wvalid;
  logic            m_axi_wready, m_axi_bvalid, m_axi_bready;
  logic [MW-1:0]   m_axi_wdata;
  logic [MW/8-1:0] m_axi_wstrb, m_axi_wuser;
  logic [1:0]      m_axi_bresp, resp_code;
  logic [3:0]      m_axi_bid, m_id;
  logic [SW-1:0]   host_to_card_tdata;
  duw_side_t       sd;
  logic            host_to_card_tvalid, host_to_card_tready;
  logic [63:0]     m_addr;
  logic [31:0]     m_seed, s_seed, s_meta, wbeat, sbeat;
  logic [12:0]     m_q;
  logic [10:0]     s_q;
  logic [7:0]      m_len, s_n, s_idx;
  logic [5:0]      s_mty;
  logic [2:0]      s_port;
  logic            s_en, s_zero, bdone, sdone;
  int              fail_count, cmp_count;

  duw_top #(.MM_DW(MW), .ST_DW(SW), .DP_EN(1'b1)) duw_top_i (
    .host_to_card_side(sd), .*);
  duw_partner duw_partner_i (.*);

  // Clock, 50 ns period
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  function automatic logic [MW/8-1:0] par(input logic [MW-1:0] d);
    for (int i = 0; i < MW / 8; i++) par[i] = ~^d[8*i+:8];
  endfunction : par

  // Reflected CRC-32 over the whole beat, LSB first
  function automatic logic [31:0] crc(input logic [SW-1:0] d);
    logic [31:0] c;
    c = '1;
    for (int i = 0; i < SW; i++)
      c = (c[0] ^ d[i]) ? (c >> 1) ^ 32'hedb88320 : c >> 1;
    return ~c;
  endfunction : crc

  task automatic chk(input logic ok, input string m);
    cmp_count++;
    if (ok !== 1'b1) begin
      fail_count++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask : chk

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : test_done

  // Register port: writes may run back to back, read data one cycle later
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    {reg_wr, reg_rd, reg_addr, reg_wdata} <= {2'b10, a, d};
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string m);
    @(posedge ref_clk);
    {reg_wr, reg_rd, reg_addr} <= {2'b01, a};
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata === e, m);
  endtask : rd

  // Bounded wait for a burst response or a packet end
  task automatic wait_for(input logic st);
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    for (int i = 0; i < 3000; i++) begin
      @(posedge ref_clk);
      if (st ? sdone : bdone) return;
    end
    fail_count++;
    $display("wrong value at %0t: engine hung", $time);
    test_done();
  endtask : wait_for

  // Monitor address, data and stream handshakes against the expected values; a response handshake only marks the burst done
  always @(posedge ref_clk) begin
    if (rst_b && m_axi_awvalid && m_axi_awready) begin
      chk(m_axi_aw.user === {m_q, 19'h0}, "aw user");
      chk(m_axi_aw.id === m_id, "aw id");
      chk({m_axi_aw.len, m_axi_aw.addr} === {m_len, m_addr}, "aw len");
      chk({m_axi_aw.burst, m_axi_aw.size, m_axi_aw.prot, m_axi_aw.lock,
        m_axi_aw.cache} === {DUW_BURST_INC, 3'($clog2(MW / 8)),
        DUW_PROT_DEF, 1'b0, DUW_CACHE_DEF}, "aw attr");
    end
    if (rst_b && m_axi_wvalid && m_axi_wready) begin
      chk({m_axi_wdata, m_axi_wstrb} ===
        {{MW/32{m_seed + wbeat}}, {MW/8{1'b1}}}, "wdata");
      chk(m_axi_wuser === par({MW/32{m_seed + wbeat}}), "wuser");
      chk(m_axi_wlast === (wbeat == m_len), "wlast");
      wbeat++;
    end
    if (m_axi_bvalid && m_axi_bready) bdone = 1'b1;
    if (rst_b && host_to_card_tvalid && host_to_card_tready) begin
      chk(host_to_card_tdata === {SW/32{s_seed + sbeat}}, "tdata");
      chk(sd.outbound_beat_crc === crc({SW/32{s_seed + sbeat}}), "crc");
      chk({sd.outbound_queue_id, sd.outbound_port_id} === {s_q, s_port}, "id");
      chk(sd.outbound_descriptor_metadata === s_meta, "meta");
      chk(sd.outbound_packet_error === (s_en && sbeat >= s_idx), "err");
      chk(sd.last === (sbeat == s_n), "last");
      chk(sd.outbound_empty_beat_flag === s_zero, "empty beat");
      chk(sd.outbound_empty_byte_count ===
        ((sbeat == s_n) ? s_mty : 6'h0), "mty");
      if (sd.last) sdone = 1'b1;
      sbeat++;
    end
  end

  task automatic mm_test(input int t);
    {m_len, m_id, m_q} = {(t == 0) ? 8'h00 : 8'($urandom % 8), 17'($urandom)};
    {m_seed, m_addr} = {$urandom, $urandom, $urandom};
    {wbeat, bdone} = 33'h0;
    @(posedge ref_clk);
    resp_code <= 2'(t);
    wr(DUW_MM_ADDR_LO, m_addr[31:0]);
    wr(DUW_MM_ADDR_HI, m_addr[63:32]);
    wr(DUW_MM_CFG_ADDR, {7'h00, m_q, m_id, m_len});
    wr(DUW_SEED_ADDR, m_seed);
    wr(DUW_INT_MASK_ADDR, {29'h0, {3{t[0]}}});
    wr(DUW_CTRL_ADDR, 32'h1);
    wait_for(1'b0);
    chk(wbeat === m_len + 1, "beat count");
    repeat (2) @(posedge ref_clk);
    chk(irq === t[0], "irq mask");
    rd(DUW_INT_STAT_ADDR, {29'h0, t[1:0] != 2'b00, 2'b01}, "int stat");
    rd(DUW_STATUS_ADDR, {24'h0, m_id, t[1:0], 2'b00}, "status");
    chk(irq === 1'b0, "irq clear");
    $display("write burst test %0d done", t);
  endtask : mm_test

  task automatic st_test(input int t);
    s_zero = (t == 1);
    s_n    = (t < 2) ? 8'h00 : (t == 3) ? 8'h04 : 8'($urandom % 6);
    s_mty  = (t == 2) ? 6'h00 : 6'($urandom);
    {s_port, s_q, s_meta, s_seed} = {14'($urandom), $urandom, $urandom};
    s_en   = (t == 3 || t == 5);
    s_idx  = (t == 3) ? 8'h00 : 8'($urandom % (s_n + 1));
    {sbeat, sdone} = 33'h0;
    wr(DUW_ST_CFG_ADDR, {1'b0, s_q, 1'b0, s_port, s_zero, 1'b0, s_mty,
      s_zero ? 8'h03 : s_n});
    wr(DUW_ST_META_ADDR, s_meta);
    wr(DUW_SEED_ADDR, s_seed);
    wr(DUW_ST_ERR_ADDR, {23'h0, s_en, s_idx});
    wr(DUW_CTRL_ADDR, 32'h2);
    wait_for(1'b1);
    chk(sbeat === s_n + 1, "beat count");
    repeat (2) @(posedge ref_clk);
    chk(irq === 1'b1, "irq set");
    rd(DUW_INT_STAT_ADDR, 32'h2, "int stat");
    $display("stream test %0d done", t);
  endtask : st_test

  // Reset, register defaults, then bursts and packets
  initial begin
    {rst_b, reg_wr, reg_rd, reg_addr, reg_wdata, resp_code} = '0;
    {fail_count, cmp_count, bdone, sdone, wbeat, sbeat} = '0;
    void'($urandom(32'h2f33f223));
    repeat (10) @(posedge ref_clk);
    rst_b <= 1'b1;
    rd(DUW_INT_STAT_ADDR, 32'h0, "stat reset");
    rd(DUW_STATUS_ADDR, 32'h0, "status reset");
    wr(8'h3c, 32'hffffffff);
    rd(8'h3c, 32'h0, "unmapped");
    chk(irq === 1'b0, "irq reset");
    for (int t = 0; t < 6; t++) mm_test(t);
    for (int t = 0; t < 6; t++) st_test(t);
    test_done();
  end
endmodule : duw_tb_top
